// >>> hw/adcreg_pkg.sv
/*
  constants of the serial register-access block of the converter:
  bus address, pointer codes, register reset values and field positions.
  assumes nothing beyond a sv-2012 compiler.
*/
package adcreg_pkg;
  // ==========================================================
  // bus address
  localparam logic [4:0] DEV_ADDR_BASE = 5'h12;
  localparam int ADDR_SEL_W = 2;

  // ==========================================================
  // register pointer codes
  localparam logic [1:0] PTR_CONVERSION = 2'h0;
  localparam logic [1:0] PTR_CONFIGURATION = 2'h1;
  localparam logic [1:0] PTR_LOW_THRESHOLD = 2'h2;
  localparam logic [1:0] PTR_HIGH_THRESHOLD = 2'h3;
  localparam logic [1:0] PTR_RESET = 2'h0;

  // ==========================================================
  // reset values
  localparam logic [15:0] CONFIG_RESET = 16'h0000;
  localparam logic [15:0] LOW_THRESHOLD_RESET = 16'h8000;
  localparam logic [15:0] HIGH_THRESHOLD_RESET = 16'h7FFF;

  // ==========================================================
  // input-select field within the configuration register
  localparam int INSEL_LSB = 12;
  localparam int INSEL_W = 3;
  localparam logic [2:0] INSEL_FIRST_VS_FOURTH = 3'h1;
  localparam logic [2:0] INSEL_THIRD_VS_FOURTH = 3'h3;

  // ==========================================================
  // byte framing
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [2:0] LAST_TX_BIT = 3'h7;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_TXACK
  } adcreg_state_e;
endpackage

// >>> hw/adcreg_pinsync.sv
/*
  two-flop synchroniser for a group of pins with rise and fall detection.
  assumes the pins are asynchronous to clk; edges are taken from the
  second and third stages only.
*/
module adcreg_pinsync #(
  parameter int W = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_q <= '1;
      sync_q <= '1;
      prev_q <= '1;
    end
    else
    begin
      meta_q <= pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;
endmodule

// >>> hw/adcreg_top.sv
/*
  two-wire serial register-access target of the converter: address match,
  pointer byte, two-byte register writes and reads of the pointed register.
  assumes the controller makes the serial clock; both wires come from
  outside the SYS_CLK domain and are oversampled by it.
*/
// Function
// - the block never drives or holds the serial clock low, so it never stretches the clock.
// - the address-select strap picks one of four bus addresses so four blocks can share a bus.
// - in a write the second byte loads the pointer and bytes three and four go to the pointed register, unless it is the conversion register.
// - pointer value one selects the configuration register.
// - a sixteen-bit register travels most significant byte first, then least significant byte.
// - standard, fast and high-speed controllers are served, master-only ones included.
// - the controller supplies the clock, data moves on the data wire, and only the data wire is driven here.
// - the input-select field offers settings measuring the first three inputs against the fourth.
module adcreg_top (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE,
  input wire logic [adcreg_pkg::ADDR_SEL_W-1:0] ADDR_SEL,
  input wire logic [15:0] CONVERSION_DATA,
  output logic [15:0] CONFIGURATION,
  output logic [15:0] LOW_THRESHOLD,
  output logic [15:0] HIGH_THRESHOLD,
  output logic [adcreg_pkg::INSEL_W-1:0] INPUT_SELECT_FIELD,
  output logic FOURTH_INPUT_COMMON,
  output logic [1:0] POINTER,
  output logic WRITE_STROBE
);
  // ==========================================================
  // pin sampling
  logic [1:0] lvl;
  logic [1:0] rise;
  logic [1:0] fall;
  logic [adcreg_pkg::ADDR_SEL_W-1:0] sel_meta_q;
  logic [adcreg_pkg::ADDR_SEL_W-1:0] sel_sync_q;
  logic [adcreg_pkg::ADDR_SEL_W-1:0] sel_q;
  logic [2:0] strap_age_q;

  adcreg_pinsync #(.W(2)) u_sync (
    .clk(SYS_CLK),
    .rst(RST),
    .pin({SCL_I, SDA_I}),
    .level(lvl),
    .rise(rise),
    .fall(fall)
  );

  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;

  assign scl = lvl[1];
  assign sda = lvl[0];
  assign scl_rise = rise[1];
  assign scl_fall = fall[1];
  assign start_c = fall[0] & scl;
  assign stop_c = rise[0] & scl;

  // ==========================================================
  // address strap, caught once on the third edge after reset release, when the synchroniser holds the pin
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      sel_meta_q <= '0;
      sel_sync_q <= '0;
      sel_q <= '0;
      strap_age_q <= '0;
    end
    else
    begin
      sel_meta_q <= ADDR_SEL;
      sel_sync_q <= sel_meta_q;
      strap_age_q <= {strap_age_q[1:0], 1'b1};
      if (strap_age_q == 3'h3)
      begin
        sel_q <= sel_sync_q;
      end
    end
  end

  logic [6:0] my_addr;
  assign my_addr = {adcreg_pkg::DEV_ADDR_BASE, sel_q};

  // ==========================================================
  // protocol engine
  adcreg_pkg::adcreg_state_e st_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic [7:0] tx_q;
  logic [2:0] nbyte_q;
  logic rw_q;
  logic lsb_next_q;
  logic ack_q;
  logic [1:0] ptr_q;
  logic [7:0] msb_q;
  logic wr_q;
  logic [15:0] wr_data_q;
  logic [15:0] rd_word;

  always_comb
  begin
    case (ptr_q)
      adcreg_pkg::PTR_CONVERSION: rd_word = CONVERSION_DATA;
      adcreg_pkg::PTR_CONFIGURATION: rd_word = CONFIGURATION;
      adcreg_pkg::PTR_LOW_THRESHOLD: rd_word = LOW_THRESHOLD;
      default: rd_word = HIGH_THRESHOLD;
    endcase
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      st_q <= adcreg_pkg::ST_IDLE;
      cnt_q <= '0;
      sh_q <= '0;
      tx_q <= '0;
      nbyte_q <= '0;
      rw_q <= 1'b0;
      lsb_next_q <= 1'b0;
      ack_q <= 1'b0;
      ptr_q <= adcreg_pkg::PTR_RESET;
      msb_q <= '0;
      wr_q <= 1'b0;
      wr_data_q <= '0;
      SDA_OE <= 1'b0;
    end
    else
    begin
      wr_q <= 1'b0;
      if (stop_c)
      begin
        st_q <= adcreg_pkg::ST_IDLE;
        SDA_OE <= 1'b0;
      end
      else if (start_c)
      begin
        st_q <= adcreg_pkg::ST_RX;
        cnt_q <= '0;
        nbyte_q <= '0;
        SDA_OE <= 1'b0;
      end
      else
      begin
        case (st_q)
          adcreg_pkg::ST_RX:
          begin
            if (scl_rise)
            begin
              sh_q <= {sh_q[6:0], sda};
              cnt_q <= cnt_q + 4'h1;
            end
            else if (scl_fall && cnt_q == adcreg_pkg::BITS_PER_BYTE)
            begin
              cnt_q <= '0;
              st_q <= adcreg_pkg::ST_ACK;
              SDA_OE <= 1'b1;
              if (nbyte_q != 3'h7)
              begin
                nbyte_q <= nbyte_q + 3'h1;
              end
              case (nbyte_q)
                3'h0:
                begin
                  if (sh_q[7:1] != my_addr)
                  begin
                    st_q <= adcreg_pkg::ST_IDLE;
                    SDA_OE <= 1'b0;
                  end
                  rw_q <= sh_q[0];
                  lsb_next_q <= 1'b0;
                end
                3'h1: ptr_q <= sh_q[1:0];
                3'h2: msb_q <= sh_q;
                3'h3:
                begin
                  wr_data_q <= {msb_q, sh_q};
                  wr_q <= 1'b1;
                end
                default: ;
              endcase
            end
          end
          adcreg_pkg::ST_ACK:
          begin
            if (scl_fall)
            begin
              if (rw_q)
              begin
                tx_q <= lsb_next_q ? rd_word[7:0] : rd_word[15:8];
                SDA_OE <= lsb_next_q ? ~rd_word[7] : ~rd_word[15];
                lsb_next_q <= ~lsb_next_q;
                cnt_q <= '0;
                st_q <= adcreg_pkg::ST_TX;
              end
              else
              begin
                SDA_OE <= 1'b0;
                st_q <= adcreg_pkg::ST_RX;
              end
            end
          end
          adcreg_pkg::ST_TX:
          begin
            if (scl_fall)
            begin
              if (cnt_q[2:0] == adcreg_pkg::LAST_TX_BIT)
              begin
                SDA_OE <= 1'b0;
                st_q <= adcreg_pkg::ST_TXACK;
              end
              else
              begin
                tx_q <= {tx_q[6:0], 1'b0};
                SDA_OE <= ~tx_q[6];
                cnt_q <= cnt_q + 4'h1;
              end
            end
          end
          adcreg_pkg::ST_TXACK:
          begin
            if (scl_rise)
            begin
              ack_q <= ~sda;
            end
            else if (scl_fall)
            begin
              if (ack_q)
              begin
                tx_q <= lsb_next_q ? rd_word[7:0] : rd_word[15:8];
                SDA_OE <= lsb_next_q ? ~rd_word[7] : ~rd_word[15];
                lsb_next_q <= ~lsb_next_q;
                cnt_q <= '0;
                st_q <= adcreg_pkg::ST_TX;
              end
              else
              begin
                st_q <= adcreg_pkg::ST_IDLE;
              end
            end
          end
          default: SDA_OE <= 1'b0;
        endcase
      end
    end
  end

  // open drain: only ever pulls low, and no clock output exists at all
  assign SDA_O = 1'b0;

  // ==========================================================
  // register file
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      CONFIGURATION <= adcreg_pkg::CONFIG_RESET;
      LOW_THRESHOLD <= adcreg_pkg::LOW_THRESHOLD_RESET;
      HIGH_THRESHOLD <= adcreg_pkg::HIGH_THRESHOLD_RESET;
    end
    else if (wr_q)
    begin
      case (ptr_q)
        adcreg_pkg::PTR_CONFIGURATION: CONFIGURATION <= wr_data_q;
        adcreg_pkg::PTR_LOW_THRESHOLD: LOW_THRESHOLD <= wr_data_q;
        adcreg_pkg::PTR_HIGH_THRESHOLD: HIGH_THRESHOLD <= wr_data_q;
        default: ;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      WRITE_STROBE <= 1'b0;
      FOURTH_INPUT_COMMON <= 1'b0;
    end
    else
    begin
      WRITE_STROBE <= wr_q;
      FOURTH_INPUT_COMMON <= INPUT_SELECT_FIELD >= adcreg_pkg::INSEL_FIRST_VS_FOURTH
        && INPUT_SELECT_FIELD <= adcreg_pkg::INSEL_THIRD_VS_FOURTH;
    end
  end

  assign INPUT_SELECT_FIELD = CONFIGURATION[adcreg_pkg::INSEL_LSB +: adcreg_pkg::INSEL_W];
  assign POINTER = ptr_q;
endmodule

// >>> bench/adcreg_properties.sv
/*
  port checks of the serial register-access block.
  assumes one clock domain; bound onto adcreg_top below.
*/
module adcreg_properties (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic SCL_I,
  input wire logic SDA_O,
  input wire logic SDA_OE,
  input wire logic [15:0] CONFIGURATION,
  input wire logic [15:0] LOW_THRESHOLD,
  input wire logic [15:0] HIGH_THRESHOLD,
  input wire logic [adcreg_pkg::INSEL_W-1:0] INPUT_SELECT_FIELD,
  input wire logic FOURTH_INPUT_COMMON,
  input wire logic [1:0] POINTER,
  input wire logic WRITE_STROBE
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // relations
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RST);
  a_pull_only:
    assert property (SDA_O == 1'h0) else $error("data output not pull-low");
  a_reset_values:
    assert property ($fell(RST) |-> CONFIGURATION == adcreg_pkg::CONFIG_RESET && POINTER == 2'h0
      && LOW_THRESHOLD == 16'h8000 && HIGH_THRESHOLD == 16'h7FFF && !SDA_OE) else $error("bad reset state");
  a_strobe_single:
    assert property (WRITE_STROBE |=> !WRITE_STROBE) else $error("strobe longer than a cycle");
  a_write_strobed:
    assert property (!$stable({CONFIGURATION, LOW_THRESHOLD, HIGH_THRESHOLD}) |-> WRITE_STROBE)
      else $error("register changed without strobe");
  a_strobe_on_ack:
    assert property (WRITE_STROBE |-> $past(SDA_OE) && !$past(SDA_OE, 2)) else $error("strobe off ack");
  a_common_follows:
    assert property (FOURTH_INPUT_COMMON == ($past(INPUT_SELECT_FIELD) inside {3'h1, 3'h2, 3'h3}))
      else $error("common flag wrong");
  a_ack_width:
    assert property ($rose(SDA_OE) |-> SDA_OE [*7]) else $error("pull too short");
  a_data_scl_low:
    assert property ($changed(SDA_OE) || $changed(POINTER) |-> !$past(SCL_I))
      else $error("change while clock high");
endmodule

bind adcreg_top adcreg_properties i_adcreg_properties (.SYS_CLK(SYS_CLK), .RST(RST), .SCL_I(SCL_I),
  .SDA_O(SDA_O), .SDA_OE(SDA_OE), .CONFIGURATION(CONFIGURATION), .LOW_THRESHOLD(LOW_THRESHOLD),
  .HIGH_THRESHOLD(HIGH_THRESHOLD), .INPUT_SELECT_FIELD(INPUT_SELECT_FIELD),
  .FOURTH_INPUT_COMMON(FOURTH_INPUT_COMMON), .POINTER(POINTER), .WRITE_STROBE(WRITE_STROBE));

// >>> bench/adcreg_ctrl_model.sv
/*
  two-wire bus controller: makes the serial clock, pulls data low.
  assumes the bench resolves the data wire with a pull-up.
*/
module adcreg_ctrl_model (
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // bus cycles, clock idle high outside frames
  initial
  begin
    scl = 1'h1;
    sda_low = 1'h0;
  end
  task automatic start();
    #7 sda_low = 1'h1;
    #80 scl = 1'h0;
    #120;
  endtask
  task automatic stop();
    sda_low = 1'h1;
    #80 scl = 1'h1;
    #80 sda_low = 1'h0;
    #80;
  endtask
  task automatic xbit(input logic b, output logic r);
    sda_low = ~b;
    #40 scl = 1'h1;
    #80 r = sda;
    #80 scl = 1'h0;
    #120;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      xbit(d[i], r);
    xbit(1'h1, r);
    ack = ~r;
  endtask
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      xbit(1'h1, d[i]);
    xbit(last, r);
  endtask
endmodule

// >>> bench/test_adcreg_top.sv
/*
  self-checking bench of the serial register-access block.
  assumes adcreg_ctrl_model as bus controller and a pull-up on data.
*/
module test_adcreg_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [1:0] sel;
    logic [1:0] p;
    logic [15:0] w;
  } adcreg_row_s;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [1:0] asel = 2'h0;
  logic [15:0] conv = 16'h5A3C;
  logic scl, sda_low, sda, sda_o, oe, com, stb;
  logic [15:0] cfg, lo, hi;
  logic [2:0] insel;
  logic [1:0] ptr;
  int errors = 0;
  int check_count = 0;
  int strobes = 0;
  adcreg_row_s rows[4] = '{'{2'h0, 2'h1, 16'h8483}, '{2'h1, 2'h2, 16'h1234},
    '{2'h2, 2'h3, 16'hABCD}, '{2'h3, 2'h1, 16'h3000}};
  assign sda = !(sda_low || (oe && !sda_o));
  always #20 clk = ~clk;
  always @(posedge clk)
  begin
    if (stb === 1'h1)
      strobes <= strobes + 1;
  end
  adcreg_ctrl_model i_adcreg_ctrl_model (.sda(sda), .scl(scl), .sda_low(sda_low));
  adcreg_top i_adcreg_top (.SYS_CLK(clk), .RST(rst), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o),
    .SDA_OE(oe), .ADDR_SEL(asel), .CONVERSION_DATA(conv), .CONFIGURATION(cfg), .LOW_THRESHOLD(lo),
    .HIGH_THRESHOLD(hi), .INPUT_SELECT_FIELD(insel), .FOURTH_INPUT_COMMON(com), .POINTER(ptr),
    .WRITE_STROBE(stb));
  // ==========================================================
  // tasks
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [6:0] dev(input logic [1:0] s);
    return {adcreg_pkg::DEV_ADDR_BASE, s};
  endfunction
  task automatic do_reset(input logic [1:0] s);
    @(posedge clk);
    asel <= s;
    rst <= 1'h1;
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    repeat (6) @(posedge clk);
  endtask
  task automatic wr(input logic [6:0] a, input logic [1:0] p, input int n, input logic [15:0] w,
    input logic ack);
    logic k;
    logic [7:0] b[4];
    b = '{{a, 1'h0}, {6'h00, p}, w[15:8], w[7:0]};
    i_adcreg_ctrl_model.start();
    for (int i = 0; i < n; i++)
    begin
      i_adcreg_ctrl_model.wbyte(b[i], k);
      cmp("write ack", {15'h0000, ack}, {15'h0000, k});
    end
    i_adcreg_ctrl_model.stop();
  endtask
  task automatic rd(input logic [6:0] a, input logic [15:0] exp);
    logic k;
    logic [15:0] d;
    i_adcreg_ctrl_model.start();
    i_adcreg_ctrl_model.wbyte({a, 1'h1}, k);
    cmp("read ack", 16'h0001, {15'h0000, k});
    i_adcreg_ctrl_model.rbyte(1'h0, d[15:8]);
    i_adcreg_ctrl_model.rbyte(1'h1, d[7:0]);
    i_adcreg_ctrl_model.stop();
    cmp("read word", exp, d);
  endtask
  task automatic end_sim();
    if (errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ==========================================================
  // sequence
  initial
  begin
    logic [2:0] ex;
    foreach (rows[i])
    begin
      do_reset(rows[i].sel);
      wr(dev(rows[i].sel), rows[i].p, 4, rows[i].w, 1'h1);
      cmp("strobe count", 16'(i + 1), 16'(strobes));
      cmp("register", rows[i].w, rows[i].p == 2'h1 ? cfg : rows[i].p == 2'h2 ? lo : hi);
      cmp("pointer", {14'h0000, rows[i].p}, {14'h0000, ptr});
      ex = rows[i].p == 2'h1 ? rows[i].w[14:12] : 3'h0;
      cmp("field", {13'h0000, ex}, {13'h0000, insel});
      cmp("common", {15'h0000, ex inside {3'h1, 3'h2, 3'h3}}, {15'h0000, com});
      rd(dev(rows[i].sel), rows[i].w);
    end
    wr(dev(2'h2), 2'h1, 1, 16'h0000, 1'h0);
    cmp("foreign address", 16'h3000, cfg);
    wr(dev(2'h3), 2'h2, 3, 16'h0F0F, 1'h1);
    cmp("three bytes", adcreg_pkg::LOW_THRESHOLD_RESET, lo);
    cmp("three byte strobe", 16'h0004, 16'(strobes));
    wr(dev(2'h3), 2'h0, 4, 16'hFFFF, 1'h1);
    rd(dev(2'h3), conv);
    wr(dev(2'h3), 2'h1, 2, 16'h0000, 1'h1);
    rd(dev(2'h3), 16'h3000);
    do_reset(2'h0);
    cmp("reset cfg", adcreg_pkg::CONFIG_RESET, cfg);
    cmp("reset high", adcreg_pkg::HIGH_THRESHOLD_RESET, hi);
    cmp("reset pointer", 16'h0000, {14'h0000, ptr});
    cmp("reset pull", 16'h0000, {15'h0000, oe});
    end_sim();
  end
  initial
  begin
    #2000000;
    errors++;
    end_sim();
  end
endmodule
